//--- hdl/sct_dev.sv
// Serial controller: registers, flags, divider chain, transmitter, receiver
// How it works
// - Empty buffer flag requests irq when enabled
// - Done flag requests irq when enabled
// - Full or overrun requests irq when enabled
// - Idle flag requests irq when enabled
// - Enabling transmitter queues one idle preamble
// - Sleep bit inhibits receiver flags and irqs
// - Break write queues break characters while set
// - Empty flag cleared by status read, data write
// - Done flag set when idle, same clearing
// - Full flag cleared by status read, data read
// - Idle flag once per busy-to-idle, sleep inhibits
// - Overrun when new character meets full buffer
// - Noise when three votes disagree
// - Framing error on zero stop bit
// - Prescaler divides by 1,3,4,13,39
// - Software keeps low bits zero with top
// - Power-of-two stage gives sampling clock
// - Bit clock is sampling clock over sixteen
// - Rate bits survive reset, change anytime
// - Reset selects prescaler divide by one
// - Hardware clears sleep on wakeup condition
// - Disabling transmitter finishes current character
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module sct_dev
  import sct_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic             serial_irq,
  sct_if.dev               link
);

  sct_dev_st_t s;
  sct_dev_st_t n;
  sct_dev_st_t rst_val;

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [4:0] reg_sel(input logic [15:0] a);
    reg_sel = {a[15:2] == `SCT_IDX_EXT,  a[15:2] == `SCT_IDX_DATA,
               a[15:2] == `SCT_IDX_STAT, a[15:2] == `SCT_IDX_CTRL,
               a[15:2] == `SCT_IDX_BAUD};
  endfunction

  function automatic logic [5:0] pre_top(input logic [2:0] sel);
    case (sel)
      3'h0:    pre_top = `SCT_PRE_DIV0 - 6'h01;
      3'h1:    pre_top = `SCT_PRE_DIV1 - 6'h01;
      3'h2:    pre_top = `SCT_PRE_DIV2 - 6'h01;
      3'h3:    pre_top = `SCT_PRE_DIV3 - 6'h01;
      3'h4:    pre_top = `SCT_PRE_DIV4 - 6'h01;
      default: pre_top = `SCT_PRE_DIV0 - 6'h01;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [4:0] sel;
    logic       setup;
    logic       acc;
    logic       start_ok;
    logic       maj;
    logic       sleeping;
    logic       idle_evt;
    logic [7:0] c;
    sel      = reg_sel(paddr);
    setup    = psel && !penable;
    acc      = psel && penable && s.pready;
    start_ok = 1'b0;
    maj      = 1'b0;
    sleeping = 1'b0;
    idle_evt = 1'b0;
    n = s;
    n.rt_tick  = 1'b0;
    n.bit_tick = 1'b0;
    n.pready   = setup;

    // Register bus, read data captured in the setup cycle
    if (setup)
    begin
      n.pslverr = !(|sel);
      n.prdata  = 32'h0000_0000;
      if (!pwrite)
        n.prdata[7:0] = ({8{sel[0]}} & s.baud) | ({8{sel[1]}} & s.ctrl) |
                        ({8{sel[2]}} & {s.stat[7:1], 1'b0}) |
                        ({8{sel[3]}} & s.rx_data) | ({8{sel[4]}} & s.ext);
    end
    if (acc && pwrite)
    begin
      if (sel[0])
        n.baud = pwdata[7:0];
      if (sel[1])
      begin
        if (pwdata[`SCT_C_TX_ON] && !s.ctrl[`SCT_C_TX_ON])
          n.pre_pend = 1'b1;
        if (pwdata[`SCT_C_BREAK])
          n.brk_pend = 1'b1;
        n.ctrl = pwdata[7:0];
      end
      if (sel[3])
      begin
        if (s.ctrl[`SCT_C_TX_ON])
        begin
          n.tx_buf      = pwdata[7:0];
          n.tx_buf_full = 1'b1;
        end
        n.stat[7:6] = s.stat[7:6] & ~s.seen[7:6];
        n.seen[7:6] = 2'h0;
      end
      if (sel[4])
        n.ext = pwdata[7:0];
    end
    if (acc && !pwrite && sel[2])
      n.seen = s.prdata[7:0];
    if (acc && !pwrite && sel[3])
    begin
      n.stat[5:1] = s.stat[5:1] & ~s.seen[5:1];
      n.seen[5:1] = 5'h00;
    end
    c = n.ctrl;

    ////////////////////////////////////////////////////////////////////////
    // Divider chain
    if (s.baud[`SCT_B_CLR])
    begin
      n.pre_cnt = 6'h00;
      n.spd_cnt = 7'h00;
      n.rt16    = 4'h0;
    end
    else
    begin
      if (s.pre_cnt >= pre_top(s.baud[`SCT_B_PRE_HI:`SCT_B_PRE_LO]))
      begin
        n.pre_cnt = 6'h00;
        if (s.spd_cnt >= ((7'h01 << s.baud[`SCT_B_SPD_HI:`SCT_B_SPD_LO])
                          - 7'h01))
        begin
          n.spd_cnt = 7'h00;
          n.rt_tick = 1'b1;
        end
        else
          n.spd_cnt = s.spd_cnt + 7'h01;
      end
      else
        n.pre_cnt = s.pre_cnt + 6'h01;
      if (s.rt_tick)
      begin
        n.rt16     = s.rt16 + 4'h1;
        n.bit_tick = (s.rt16 == `SCT_RT_LAST);
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    if (s.bit_tick)
    begin
      if (s.tx_st != SCT_TX_IDLE && s.tx_cnt != `SCT_FRAME_LEN)
      begin
        n.txd      = s.tx_shift[0];
        n.tx_shift = {1'b1, s.tx_shift[8:1]};
        n.tx_cnt   = s.tx_cnt + 4'h1;
      end
      else
        start_ok = 1'b1;
    end
    if (start_ok)
    begin
      n.tx_cnt = 4'h1;
      if (!c[`SCT_C_TX_ON])
      begin
        n.tx_buf_full = 1'b0;
        n.pre_pend    = 1'b0;
        n.brk_pend    = 1'b0;
        n.txd         = 1'b1;
        n.tx_st       = SCT_TX_IDLE;
        n.stat[`SCT_S_TXE] = 1'b1;
        n.stat[`SCT_S_TXD] = 1'b1;
      end
      else if (s.pre_pend)
      begin
        n.pre_pend = 1'b0;
        n.txd      = 1'b1;
        n.tx_shift = 9'h1ff;
        n.tx_st    = SCT_TX_PRE;
      end
      else if (s.brk_pend || c[`SCT_C_BREAK])
      begin
        n.brk_pend = 1'b0;
        n.txd      = 1'b0;
        n.tx_shift = 9'h000;
        n.tx_st    = SCT_TX_BRK;
      end
      else if (s.tx_buf_full)
      begin
        n.tx_buf_full = 1'b0;
        n.txd         = 1'b0;
        n.tx_shift    = {1'b1, s.tx_buf};
        n.tx_st       = SCT_TX_DATA;
        n.stat[`SCT_S_TXE] = 1'b1;
      end
      else
      begin
        n.txd   = 1'b1;
        n.tx_st = SCT_TX_IDLE;
        n.stat[`SCT_S_TXD] = 1'b1;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver
    n.rx_sync = {s.rx_sync[1:0], link.dev_rxd};
    if (s.rx_sync[1] == s.rx_sync[2])
      n.rx_lvl = s.rx_sync[2];
    if (!c[`SCT_C_RX_ON])
    begin
      n.rx_st    = SCT_RX_IDLE;
      n.idle_cnt = 8'h00;
    end
    else if (s.rt_tick)
    begin
      if (!s.rx_lvl)
      begin
        n.idle_cnt   = 8'h00;
        n.idle_armed = 1'b1;
      end
      else if (s.idle_cnt != `SCT_IDLE_RT)
      begin
        n.idle_cnt = s.idle_cnt + 8'h01;
        idle_evt   = s.idle_armed && (n.idle_cnt == `SCT_IDLE_RT);
      end
      if (idle_evt)
      begin
        n.idle_armed = 1'b0;
        if (c[`SCT_C_SLEEP] && !s.ext[`SCT_E_WAKE_MARK])
          n.ctrl[`SCT_C_SLEEP] = 1'b0;
        else if (!c[`SCT_C_SLEEP])
          n.stat[`SCT_S_IDLE] = 1'b1;
      end
      case (s.rx_st)
        SCT_RX_IDLE:
        begin
          if (!s.rx_lvl)
          begin
            n.rx_st    = SCT_RX_BUSY;
            n.rx_rt    = 4'h0;
            n.rx_bitn  = 4'h0;
            n.rx_noise = 1'b0;
          end
        end
        SCT_RX_BUSY:
        begin
          n.rx_rt = s.rx_rt + 4'h1;
          if (s.rx_rt == `SCT_VOTE_A || s.rx_rt == `SCT_VOTE_B ||
              s.rx_rt == `SCT_VOTE_C)
            n.votes = {s.votes[1:0], s.rx_lvl};
          if (s.rx_rt == `SCT_RT_LAST)
          begin
            maj = (s.votes[0] & s.votes[1]) | (s.votes[0] & s.votes[2]) |
                  (s.votes[1] & s.votes[2]);
            n.rx_noise = s.rx_noise || !(&s.votes == |s.votes);
            n.rx_bitn  = s.rx_bitn + 4'h1;
            if (s.rx_bitn == 4'h0 && maj)
              n.rx_st = SCT_RX_IDLE;
            else if (s.rx_bitn != `SCT_STOP_POS && s.rx_bitn != 4'h0)
              n.rx_shift = {maj, s.rx_shift[7:1]};
            else if (s.rx_bitn == `SCT_STOP_POS)
            begin
              n.rx_st  = SCT_RX_IDLE;
              sleeping = c[`SCT_C_SLEEP];
              if (sleeping && s.ext[`SCT_E_WAKE_MARK] && s.rx_shift[7])
              begin
                n.ctrl[`SCT_C_SLEEP] = 1'b0;
                sleeping = 1'b0;
              end
              if (!sleeping)
              begin
                if (s.stat[`SCT_S_RXF] || s.stat[`SCT_S_FRAME])
                  n.stat[`SCT_S_OVR] = 1'b1;
                else
                begin
                  n.rx_data = s.rx_shift;
                  n.stat[`SCT_S_RXF]   = 1'b1;
                  n.stat[`SCT_S_NOISE] = n.rx_noise;
                  n.stat[`SCT_S_FRAME] = !maj;
                end
              end
            end
          end
        end
        default:
          n.rx_st = SCT_RX_IDLE;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request
    n.irq = (n.ctrl[`SCT_C_TXE_IE] && n.stat[`SCT_S_TXE]) ||
            (n.ctrl[`SCT_C_TXD_IE] && n.stat[`SCT_S_TXD]) ||
            (n.ctrl[`SCT_C_RXF_IE] &&
             (n.stat[`SCT_S_RXF] || n.stat[`SCT_S_OVR])) ||
            (n.ctrl[`SCT_C_IDL_IE] && n.stat[`SCT_S_IDLE]);
    if (n.ctrl[`SCT_C_SLEEP])
      n.irq = (n.ctrl[`SCT_C_TXE_IE] && n.stat[`SCT_S_TXE]) ||
              (n.ctrl[`SCT_C_TXD_IE] && n.stat[`SCT_S_TXD]);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_comb
  begin
    rst_val = '0;
    rst_val.baud     = `SCT_BAUD_RST;
    rst_val.ctrl     = `SCT_CTRL_RST;
    rst_val.ext      = `SCT_EXT_RST;
    rst_val.stat     = `SCT_STAT_RST;
    rst_val.tx_st    = SCT_TX_IDLE;
    rst_val.tx_shift = 9'h1ff;
    rst_val.txd      = 1'b1;
    rst_val.rx_sync  = 3'h7;
    rst_val.rx_lvl   = 1'b1;
    rst_val.rx_st    = SCT_RX_IDLE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s <= rst_val;
      s.baud[`SCT_B_SPD_HI:`SCT_B_SPD_LO] <=
        s.baud[`SCT_B_SPD_HI:`SCT_B_SPD_LO];
    end
    else
      s <= n;
  end

  assign pready       = s.pready;
  assign pslverr      = s.pslverr;
  assign prdata       = s.prdata;
  assign serial_irq   = s.irq;
  assign link.dev_txd = s.txd;

endmodule

//--- hdl/sct_params.svh
// Offsets, field positions, reset values and timing counts of the serial block
`ifndef SCT_PARAMS_SVH
`define SCT_PARAMS_SVH
// Register indices, byte address is four times the index
`define SCT_IDX_BAUD 14'h102b
`define SCT_IDX_CTRL 14'h102d
`define SCT_IDX_STAT 14'h102e
`define SCT_IDX_DATA 14'h102f
`define SCT_IDX_EXT  14'h1030
// Control two fields
`define SCT_C_TXE_IE 7
`define SCT_C_TXD_IE 6
`define SCT_C_RXF_IE 5
`define SCT_C_IDL_IE 4
`define SCT_C_TX_ON  3
`define SCT_C_RX_ON  2
`define SCT_C_SLEEP  1
`define SCT_C_BREAK  0
// Status fields
`define SCT_S_TXE    7
`define SCT_S_TXD    6
`define SCT_S_RXF    5
`define SCT_S_IDLE   4
`define SCT_S_OVR    3
`define SCT_S_NOISE  2
`define SCT_S_FRAME  1
// Divider select fields
`define SCT_B_CLR    7
`define SCT_B_PRE_HI 6
`define SCT_B_PRE_LO 4
`define SCT_B_CHK    3
`define SCT_B_SPD_HI 2
`define SCT_B_SPD_LO 0
// Extra control fields
`define SCT_E_WAKE_MARK 0
// Reset values
`define SCT_CTRL_RST 8'h00
`define SCT_STAT_RST 8'hc0
`define SCT_BAUD_RST 8'h00
`define SCT_EXT_RST  8'h00
// Prescaler divisors
`define SCT_PRE_DIV0 6'h01
`define SCT_PRE_DIV1 6'h03
`define SCT_PRE_DIV2 6'h04
`define SCT_PRE_DIV3 6'h0d
`define SCT_PRE_DIV4 6'h27
// Sampling ticks per bit and character timing
`define SCT_RT_LAST   4'hf
`define SCT_VOTE_A    4'h7
`define SCT_VOTE_B    4'h8
`define SCT_VOTE_C    4'h9
`define SCT_FRAME_LEN 4'ha
`define SCT_STOP_POS  4'h9
`define SCT_IDLE_RT   8'h9f
`endif

//--- hdl/sct_pkg.sv
// Types shared by both ends of the serial link
`include "sct_params.svh"
package sct_pkg;

  typedef enum logic [3:0]
  {
    SCT_TX_IDLE = 4'h1,
    SCT_TX_PRE  = 4'h2,
    SCT_TX_BRK  = 4'h4,
    SCT_TX_DATA = 4'h8
  } sct_txs_t;

  typedef enum logic [1:0]
  {
    SCT_RX_IDLE = 2'h1,
    SCT_RX_BUSY = 2'h2
  } sct_rxs_t;

  typedef struct packed
  {
    logic [7:0]  baud;
    logic [7:0]  ctrl;
    logic [7:0]  ext;
    logic [7:0]  stat;
    logic [7:0]  seen;
    logic [5:0]  pre_cnt;
    logic [6:0]  spd_cnt;
    logic [3:0]  rt16;
    logic        rt_tick;
    logic        bit_tick;
    sct_txs_t    tx_st;
    logic [8:0]  tx_shift;
    logic [3:0]  tx_cnt;
    logic [7:0]  tx_buf;
    logic        tx_buf_full;
    logic        pre_pend;
    logic        brk_pend;
    logic        txd;
    logic [2:0]  rx_sync;
    logic        rx_lvl;
    sct_rxs_t    rx_st;
    logic [3:0]  rx_rt;
    logic [3:0]  rx_bitn;
    logic [2:0]  votes;
    logic        rx_noise;
    logic [7:0]  rx_shift;
    logic [7:0]  rx_data;
    logic [7:0]  idle_cnt;
    logic        idle_armed;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
  } sct_dev_st_t;

  typedef struct packed
  {
    sct_txs_t    tx_st;
    logic [15:0] tx_tmr;
    logic [3:0]  tx_cnt;
    logic [9:0]  tx_shift;
    logic        txd;
    logic        tx_ready;
    logic [2:0]  rx_sync;
    sct_rxs_t    rx_st;
    logic [15:0] rx_tmr;
    logic [3:0]  rx_bitn;
    logic [7:0]  rx_shift;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        rx_ferr;
  } sct_node_st_t;

endpackage

//--- hdl/sct_if.sv
// Serial line pair between the controller and the remote node
`timescale 1ns/1ps
interface sct_if;
  logic dev_txd;
  logic dev_rxd;
  modport dev  (output dev_txd, input dev_rxd);
  modport node (input dev_txd, output dev_rxd);
endinterface

//--- hdl/sct_node.sv
// Remote serial node: one start bit, eight data bits, one stop bit
`timescale 1ns/1ps
module sct_node
  import sct_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] bit_cycles,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  output logic             rx_frame_err,
  sct_if.node              link
);

  sct_node_st_t s;
  sct_node_st_t n;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    n = s;
    n.rx_valid = 1'b0;
    n.rx_sync  = {s.rx_sync[1:0], link.dev_txd};

    // Transmit
    case (s.tx_st)
      SCT_TX_IDLE:
      begin
        n.tx_ready = 1'b1;
        if (tx_valid && s.tx_ready)
        begin
          n.tx_ready = 1'b0;
          n.tx_shift = {1'b1, tx_data, 1'b0};
          n.tx_cnt   = 4'h0;
          n.tx_tmr   = 16'h0000;
          n.tx_st    = SCT_TX_DATA;
        end
      end
      SCT_TX_DATA:
      begin
        n.txd    = s.tx_shift[0];
        n.tx_tmr = s.tx_tmr + 16'h0001;
        if (s.tx_tmr >= bit_cycles - 16'h0001)
        begin
          n.tx_tmr   = 16'h0000;
          n.tx_shift = {1'b1, s.tx_shift[9:1]};
          n.tx_cnt   = s.tx_cnt + 4'h1;
          if (s.tx_cnt == `SCT_STOP_POS)
          begin
            n.tx_st    = SCT_TX_IDLE;
            n.tx_ready = 1'b1;
          end
        end
      end
      default:
        n.tx_st = SCT_TX_IDLE;
    endcase

    // Receive, sampling at mid-bit
    case (s.rx_st)
      SCT_RX_IDLE:
      begin
        if (s.rx_sync[1] == s.rx_sync[2] && !s.rx_sync[2])
        begin
          n.rx_st   = SCT_RX_BUSY;
          n.rx_tmr  = {1'b0, bit_cycles[15:1]};
          n.rx_bitn = 4'h0;
        end
      end
      SCT_RX_BUSY:
      begin
        n.rx_tmr = s.rx_tmr + 16'h0001;
        if (s.rx_tmr >= bit_cycles - 16'h0001)
        begin
          n.rx_tmr  = 16'h0000;
          n.rx_bitn = s.rx_bitn + 4'h1;
          if (s.rx_bitn == 4'h0 && s.rx_sync[2])
            n.rx_st = SCT_RX_IDLE;
          else if (s.rx_bitn == `SCT_STOP_POS)
          begin
            n.rx_st    = SCT_RX_IDLE;
            n.rx_data  = s.rx_shift;
            n.rx_ferr  = !s.rx_sync[2];
            n.rx_valid = 1'b1;
          end
          else if (s.rx_bitn != 4'h0)
            n.rx_shift = {s.rx_sync[2], s.rx_shift[7:1]};
        end
      end
      default:
        n.rx_st = SCT_RX_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s          <= '0;
      s.tx_st    <= SCT_TX_IDLE;
      s.tx_shift <= 10'h3ff;
      s.txd      <= 1'b1;
      s.rx_sync  <= 3'h7;
      s.rx_st    <= SCT_RX_IDLE;
    end
    else
      s <= n;
  end

  assign tx_ready     = s.tx_ready;
  assign rx_data      = s.rx_data;
  assign rx_valid     = s.rx_valid;
  assign rx_frame_err = s.rx_ferr;
  assign link.dev_rxd = s.txd;

endmodule

//--- verif/sct_props.sv
// Checker for the controller bus and the controller's transmit line
`timescale 1ns/1ps
`include "sct_params.svh"
module sct_props
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        serial_irq,
  input wire logic        dev_txd,
  input wire logic        dev_rxd
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic       hit;
  logic       rd_stat;
  logic       setup;
  logic       txd_q_r;
  logic [7:0] run_r;
  ////////////////////////////////////////////////////////////////////////////
  // Decode and line run length
  assign setup = psel && !penable;
  assign hit = paddr[15:2] inside {`SCT_IDX_BAUD, `SCT_IDX_CTRL,
    `SCT_IDX_STAT, `SCT_IDX_DATA, `SCT_IDX_EXT};
  assign rd_stat = pready && !pwrite && paddr[15:2] == `SCT_IDX_STAT;
  always_ff @(posedge sys_clk)
  begin
    txd_q_r <= dev_txd;
    if (!rst_n || dev_txd != txd_q_r)
      run_r <= 8'h00;
    else if (run_r != 8'hff)
      run_r <= run_r + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Properties
  a_ready_next: assert property (setup |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_unmapped: assert property (setup && !hit |=> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (setup && hit |=> !pslverr)
    else $error("error on mapped address");
  a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_stat_bit0: assert property (rd_stat |-> !prdata[0])
    else $error("status bit zero set");
  a_tx_bit_len: assert property (dev_txd != txd_q_r |-> run_r >= 8'd15)
    else $error("line bit shorter than sixteen cycles");
  a_txd_reset_idle: assert property ($rose(rst_n) |-> dev_txd)
    else $error("line not idle after reset");
  a_irq_reset_quiet: assert property ($rose(rst_n) |-> !serial_irq)
    else $error("irq raised after reset");
  c_stat_read: cover property (rd_stat && prdata[7]);
  c_txd_fall: cover property ($fell(dev_txd));
  c_irq_rise: cover property ($rose(serial_irq));
endmodule

//--- verif/sct_tb.sv
// Testbench joining the serial controller to the remote node
`timescale 1ns/1ps
`include "sct_params.svh"
module sct_tb;
  localparam logic [13:0] i_bau = `SCT_IDX_BAUD;
  localparam logic [13:0] i_ctl = `SCT_IDX_CTRL;
  localparam logic [13:0] i_sta = `SCT_IDX_STAT;
  localparam logic [13:0] i_dat = `SCT_IDX_DATA;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        serial_irq, tx_valid, tx_ready, rx_valid, rx_frame_err;
  logic        last_err;
  logic [15:0] paddr, bit_cycles;
  logic [31:0] pwdata, prdata;
  logic [7:0]  tx_data, rx_data, s;
  logic [7:0]  ien [4] = '{8'h80, 8'h40, 8'h20, 8'h10};
  // Top prescaler bit only with low bits zero
  logic [7:0]  bsel [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h01};
  logic [15:0] bcyc [6] = '{16, 48, 64, 208, 624, 32};
  int          fail_count = 0;
  int          n_checks = 0;
  int          n;
  sct_if sct_if_inst ();
  sct_dev sct_dev_inst
  (
    .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .serial_irq, .link(sct_if_inst.dev)
  );
  sct_node sct_node_inst
  (
    .sys_clk, .rst_n, .bit_cycles, .tx_data, .tx_valid, .tx_ready,
    .rx_data, .rx_valid, .rx_frame_err, .link(sct_if_inst.node)
  );
  sct_props sct_props_inst
  (
    .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
    .prdata, .serial_irq, .dev_txd(sct_if_inst.dev_txd),
    .dev_rxd(sct_if_inst.dev_rxd)
  );
  always #2.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic [13:0] i, input logic w, input logic [7:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    for (int j = 0; pready !== 1'b1 && j < 64; j++)
      @(posedge sys_clk);
    if (pready !== 1'b1)
      fail_count++;
    s = prdata[7:0];
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [13:0] i, input logic [7:0] d);
    apb(i, 1'b1, d);
  endtask
  task automatic rdc(input logic [13:0] i, input logic [7:0] m, e);
    apb(i, 1'b0, 8'h00);
    chk($sformatf("reg %h", i), e, s & m);
  endtask
  task automatic poll(input logic [7:0] m);
    apb(i_sta, 1'b0, 8'h00);
    for (int j = 0; (s & m) !== m && j < 4000; j++)
      apb(i_sta, 1'b0, 8'h00);
    chk("status poll", m, s & m);
  endtask
  task automatic nsend(input logic [7:0] d);
    tx_data  <= d;
    tx_valid <= 1'b1;
    @(posedge sys_clk);
    tx_valid <= 1'b0;
    @(posedge sys_clk);
    for (int j = 0; tx_ready !== 1'b1 && j < 20000; j++)
      @(posedge sys_clk);
    chk("node ready", 8'h01, {7'h0, tx_ready});
  endtask
  task automatic nwait(input logic [7:0] d, input logic fe);
    for (n = 0; rx_valid !== 1'b1 && n < 20000; n++)
      @(posedge sys_clk);
    chk("node data", d, rx_data);
    chk("node frame", {7'h0, fe}, {7'h0, rx_frame_err});
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(posedge sys_clk);
    chk("irq", {7'h0, v}, {7'h0, serial_irq});
  endtask
  task automatic results;
    if (fail_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #500000;
    fail_count++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial
  begin
    {sys_clk, rst_n, psel, penable, pwrite, tx_valid} = '0;
    {paddr, pwdata, tx_data} = '0;
    bit_cycles = 16'd16;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    wr(i_bau, 8'h75);
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdc(i_bau, 8'hff, 8'h05);
    rdc(i_ctl, 8'hff, 8'h00);
    wr(i_sta, 8'h00);
    rdc(i_sta, 8'hff, 8'hc0);
    apb(14'h1031, 1'b0, 8'h00);
    chk("unmapped", 8'h01, {7'h0, last_err});
    wr(i_bau, 8'h00);
    wr(i_ctl, 8'h0c);
    rdc(i_sta, 8'h80, 8'h80);
    wr(i_dat, 8'ha5);
    rdc(i_sta, 8'h80, 8'h00);
    nwait(8'ha5, 1'b0);
    chk("preamble", 8'h01, {7'h0, n > 280});
    poll(8'hc0);
    nsend(8'h3c);
    poll(8'h20);
    rdc(i_sta, 8'h06, 8'h00);
    rdc(i_dat, 8'hff, 8'h3c);
    rdc(i_sta, 8'h20, 8'h00);
    nsend(8'h11);
    nsend(8'h22);
    poll(8'h28);
    rdc(i_dat, 8'hff, 8'h11);
    rdc(i_sta, 8'h28, 8'h00);
    poll(8'h10);
    rdc(i_dat, 8'h00, 8'h00);
    repeat (400) @(posedge sys_clk);
    rdc(i_sta, 8'h10, 8'h00);
    foreach (ien[k])
    begin
      wr(i_ctl, ien[k] | 8'h0c);
      irq_is(k < 2);
    end
    wr(i_ctl, 8'h2c);
    nsend(8'h55);
    poll(8'h20);
    irq_is(1'b1);
    rdc(i_dat, 8'hff, 8'h55);
    irq_is(1'b0);
    wr(i_ctl, 8'h1c);
    poll(8'h10);
    irq_is(1'b1);
    rdc(i_dat, 8'h00, 8'h00);
    wr(`SCT_IDX_EXT, 8'h01);
    wr(i_ctl, 8'h0e);
    nsend(8'h12);
    nsend(8'h92);
    poll(8'h20);
    rdc(i_dat, 8'hff, 8'h92);
    rdc(i_ctl, 8'h02, 8'h00);
    wr(i_ctl, 8'h0d);
    nwait(8'h00, 1'b1);
    nwait(8'h00, 1'b1);
    wr(i_ctl, 8'h0c);
    poll(8'h40);
    // Node resyncs on the tail of the break before the next character
    repeat (320) @(posedge sys_clk);
    wr(i_dat, 8'h81);
    poll(8'h80);
    wr(i_ctl, 8'h00);
    nwait(8'h81, 1'b0);
    wr(i_ctl, 8'h0c);
    foreach (bsel[k])
    begin
      wr(i_bau, bsel[k]);
      bit_cycles <= bcyc[k];
      nsend(8'h30 | 8'(k));
      poll(8'h20);
      rdc(i_dat, 8'hff, 8'h30 | 8'(k));
      wr(i_dat, 8'ha0 | 8'(k));
      nwait(8'ha0 | 8'(k), 1'b0);
    end
    wr(i_ctl, 8'h08);
    nsend(8'h77);
    rdc(i_sta, 8'h2e, 8'h00);
    results();
  end
endmodule
